/* File: logic/irt_pkg.sv */
// Purpose: Shared constants for the infrared carrier modulation timer.
// Assumes: APB register map with 32-bit aligned words.
// Notes:   All offsets are byte addresses.

`default_nettype none

package irt_pkg;

   // ****************************************************
   // Register offsets
   // ****************************************************
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] CARRIER_PERIOD_OFFSET = 8'h04;
   localparam logic [7:0] MARK_INTERVAL_OFFSET = 8'h08;
   localparam logic [7:0] INTERVAL_COUNT_OFFSET = 8'h0C;
   localparam logic [7:0] STATUS_OFFSET = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h14;
   localparam logic [7:0] POWER_CONTROL_OFFSET = 8'h18;

   // ****************************************************
   // Control register fields
   // ****************************************************
   localparam int CTRL_TIMER_ON_BIT = 0;
   localparam int CTRL_TX_RX_BIT = 1;
   localparam int CTRL_POLARITY_BIT = 2;
   localparam int CTRL_MARK_BIT = 3;
   localparam int CTRL_CLK_SEL_BIT = 4;
   localparam int CTRL_DIV_LSB = 5;
   localparam int CTRL_EDGE_LSB = 7;
   localparam int CTRL_RELOAD_BIT = 9;
   localparam int CTRL_IRQ_EN_BIT = 10;
   localparam int CTRL_WIDTH = 11;

   // ****************************************************
   // Status, power control and edge select codes
   // ****************************************************
   localparam int STATUS_INTERVAL_BIT = 0;
   localparam int STATUS_OVERFLOW_BIT = 1;
   localparam int STATUS_WIDTH = 2;
   localparam int PWR_LEVEL_BIT = 0;
   localparam int PWR_DRIVE_BIT = 1;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 11'h000;
   localparam logic [15:0] PERIOD_RESET = 16'h0000;
   localparam logic [15:0] INTERVAL_RESET = 16'h0000;
   localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] PWR_RESET = 2'h0;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;

endpackage : irt_pkg

`default_nettype wire

/* File: logic/irt_clk_div.sv */
// Purpose: Power-of-two divider giving the carrier input clock enable.
// Assumes: One system clock; output is a one-cycle enable pulse.
// Notes:   Divide code 0 gives a pulse every cycle.

`timescale 1ns/1ps
`default_nettype none

module irt_clk_div #(
   parameter int DIV_WIDTH = 2
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [DIV_WIDTH-1:0] divSel,
   output logic tick
);

   localparam int CNT_WIDTH = (1 << DIV_WIDTH) - 1;

   logic [CNT_WIDTH-1:0] divCnt_reg;
   logic [CNT_WIDTH-1:0] divMask;

   assign divMask = CNT_WIDTH'((1 << divSel) - 1);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         divCnt_reg <= '0;
      end else begin
         divCnt_reg <= divCnt_reg + 1'b1;
      end
   end

   // Pulse when all selected low bits are set
   assign tick = ((divCnt_reg & divMask) == divMask);

endmodule // irt_clk_div

`default_nettype wire

/* File: logic/irt_carrier_gen.sv */
// Purpose: Carrier generator timed by the carrier input clock enable.
// Assumes: Counts are latched by the caller for each interval.
// Notes:   carrierTick pulses once at the end of each full period.

`timescale 1ns/1ps
`default_nettype none

module irt_carrier_gen #(
   parameter int COUNT_WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic restart,
   input wire logic inTick,
   input wire logic [COUNT_WIDTH-1:0] highCount,
   input wire logic [COUNT_WIDTH-1:0] lowCount,
   output logic carrierLevel,
   output logic carrierTick
);

   logic [COUNT_WIDTH-1:0] phaseCnt_reg;
   logic highPhase_reg;
   logic tick_reg;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         phaseCnt_reg <= '0;
         highPhase_reg <= 1'b1;
         tick_reg <= 1'b0;
      end else if (!run || restart) begin
         phaseCnt_reg <= highCount;
         highPhase_reg <= 1'b1;
         tick_reg <= 1'b0;
      end else if (inTick) begin
         // RL2 RL4 high count+1 then low count+1
         if (phaseCnt_reg == '0) begin
            highPhase_reg <= !highPhase_reg;
            phaseCnt_reg <= highPhase_reg ? lowCount : highCount;
            tick_reg <= !highPhase_reg;
         end else begin
            phaseCnt_reg <= phaseCnt_reg - 1'b1;
            tick_reg <= 1'b0;
         end
      end else begin
         tick_reg <= 1'b0;
      end
   end

   assign carrierLevel = highPhase_reg;
   assign carrierTick = tick_reg;

endmodule // irt_carrier_gen

`default_nettype wire

/* File: logic/irt_carrier_timer.sv */
// Purpose: Infrared carrier generation and modulation timer, APB slave.
// Assumes: Single 200 MHz core clock, synchronous active-low reset.
// Notes:   Sense pin is asynchronous and passes two flip-flops.

`timescale 1ns/1ps
`default_nettype none

// Function
// RL1 - Timer off: software drives emit pin
// RL2 - Carrier high/low last count plus one
// RL3 - Input clock is system clock over 2^div
// RL4 - Period is both counts plus two
// RL5 - Latch period, mark, polarity per interval
// RL6 - Enabled timer idles emit pin at polarity
// RL7 - Mark one sends carrier, else idle level
// RL8 - Count clock: carrier or input clock
// RL9 - Transmit starts when on and tx both set
// RL10 - Start loads counter from mark interval
// RL11 - Zero then tick: reload, resample, flag
// RL12 - Interval lasts mark interval plus one
// RL13 - Software stops via receive or off
// RL14 - Receive counts up, optional capture reload
// RL15 - Rollover sets overflow flag, interrupts
// RL16 - Capture on selected sense pin edges
// RL17 - Capture stores level and counter value
// RL18 - Flags stick until software clears them
module irt_carrier_timer #(
   parameter int DIV_WIDTH = 2,
   parameter int COUNT_WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sensePin,
   output logic emitPinOut,
   output logic emitPinOeN,
   output logic irq
);

   // ****************************************************
   // Declarations
   // ****************************************************
   logic [irt_pkg::CTRL_WIDTH-1:0] ctrl_reg;
   logic [15:0] carrierPeriod_reg;
   logic [COUNT_WIDTH-1:0] markInterval_reg;
   logic [COUNT_WIDTH-1:0] intervalCounter_reg;
   logic [irt_pkg::STATUS_WIDTH-1:0] status_reg;
   logic [irt_pkg::STATUS_WIDTH-1:0] irqMask_reg;
   logic [1:0] powerControl_reg;
   logic markBit_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;
   logic emitOut_reg;
   logic emitOeN_reg;
   logic senseMeta_reg;
   logic senseSync_reg;
   logic sensePrev_reg;
   logic txActivePrev_reg;
   logic [15:0] latchedPeriod_reg;
   logic latchedMark_reg;
   logic latchedPol_reg;
   logic [31:0] readMux;
   logic mapped;
   logic writeDone;
   logic timerOn;
   logic txMode;
   logic txActive;
   logic rxActive;
   logic txStart;
   logic inTick;
   logic carrierLevel;
   logic carrierTick;
   logic countTick;
   logic intervalEnd;
   logic rollOver;
   logic riseEdge;
   logic fallEdge;
   logic captureEvent;
   logic [irt_pkg::STATUS_WIDTH-1:0] statusSet;
   logic [irt_pkg::STATUS_WIDTH-1:0] statusClr;
   logic [1:0] edgeSel;

   assign timerOn = ctrl_reg[irt_pkg::CTRL_TIMER_ON_BIT];
   assign txMode = ctrl_reg[irt_pkg::CTRL_TX_RX_BIT];
   assign edgeSel = ctrl_reg[irt_pkg::CTRL_EDGE_LSB +: 2];
   assign txActive = timerOn && txMode;
   assign rxActive = timerOn && !txMode;

   // ****************************************************
   // APB slave
   // ****************************************************
   // One wait state: data is registered on the same edge that pready rises
   assign writeDone = psel && penable && pready_reg && pwrite && mapped;

   always_comb begin
      readMux = irt_pkg::DATA_RESET;
      mapped = 1'b1;
      if (paddr == irt_pkg::CTRL_OFFSET) begin
         readMux[irt_pkg::CTRL_WIDTH-1:0] = ctrl_reg;
         readMux[irt_pkg::CTRL_MARK_BIT] = markBit_reg;
      end else if (paddr == irt_pkg::CARRIER_PERIOD_OFFSET) begin
         readMux[15:0] = carrierPeriod_reg;
      end else if (paddr == irt_pkg::MARK_INTERVAL_OFFSET) begin
         readMux[COUNT_WIDTH-1:0] = markInterval_reg;
      end else if (paddr == irt_pkg::INTERVAL_COUNT_OFFSET) begin
         readMux[COUNT_WIDTH-1:0] = intervalCounter_reg;
      end else if (paddr == irt_pkg::STATUS_OFFSET) begin
         readMux[irt_pkg::STATUS_WIDTH-1:0] = status_reg;
      end else if (paddr == irt_pkg::IRQ_MASK_OFFSET) begin
         readMux[irt_pkg::STATUS_WIDTH-1:0] = irqMask_reg;
      end else if (paddr == irt_pkg::POWER_CONTROL_OFFSET) begin
         readMux[1:0] = powerControl_reg;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pready_reg <= 1'b0;
         prdata_reg <= irt_pkg::DATA_RESET;
         pslverr_reg <= 1'b0;
      end else if (psel && penable && !pready_reg) begin
         pready_reg <= 1'b1;
         prdata_reg <= pwrite ? irt_pkg::DATA_RESET : readMux;
         pslverr_reg <= !mapped;
      end else begin
         pready_reg <= 1'b0;
         prdata_reg <= irt_pkg::DATA_RESET;
         pslverr_reg <= 1'b0;
      end
   end

   // ****************************************************
   // Software registers
   // ****************************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ctrl_reg <= irt_pkg::CTRL_RESET;
         carrierPeriod_reg <= irt_pkg::PERIOD_RESET;
         irqMask_reg <= irt_pkg::STATUS_RESET;
         powerControl_reg <= irt_pkg::PWR_RESET;
      end else if (writeDone) begin
         if (paddr == irt_pkg::CTRL_OFFSET) begin
            ctrl_reg <= pwdata[irt_pkg::CTRL_WIDTH-1:0];
         end else if (paddr == irt_pkg::CARRIER_PERIOD_OFFSET) begin
            carrierPeriod_reg <= pwdata[15:0];
         end else if (paddr == irt_pkg::IRQ_MASK_OFFSET) begin
            irqMask_reg <= pwdata[irt_pkg::STATUS_WIDTH-1:0];
         end else if (paddr == irt_pkg::POWER_CONTROL_OFFSET) begin
            powerControl_reg <= pwdata[1:0];
         end
      end
   end

   // ****************************************************
   // Sense pin synchroniser and edge detect
   // ****************************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         senseMeta_reg <= 1'b0;
         senseSync_reg <= 1'b0;
         sensePrev_reg <= 1'b0;
      end else begin
         senseMeta_reg <= sensePin;
         senseSync_reg <= senseMeta_reg;
         sensePrev_reg <= senseSync_reg;
      end
   end

   assign riseEdge = senseSync_reg && !sensePrev_reg;
   assign fallEdge = !senseSync_reg && sensePrev_reg;

   // RL16 edge qualification
   always_comb begin
      case (edgeSel)
         irt_pkg::EDGE_RISE: captureEvent = rxActive && riseEdge;
         irt_pkg::EDGE_FALL: captureEvent = rxActive && fallEdge;
         irt_pkg::EDGE_BOTH: captureEvent = rxActive && (riseEdge || fallEdge);
         default: captureEvent = 1'b0;
      endcase
   end

   // ****************************************************
   // Clock divider and carrier generator
   // ****************************************************
   // RL3 input clock enable
   irt_clk_div #(
      .DIV_WIDTH(DIV_WIDTH)
   ) u_div (
      .core_clk(core_clk),
      .rstn(rstn),
      .divSel(ctrl_reg[irt_pkg::CTRL_DIV_LSB +: DIV_WIDTH]),
      .tick(inTick)
   );

   // RL2 RL5 per-interval copy, live value at start
   irt_carrier_gen #(
      .COUNT_WIDTH(8)
   ) u_carrier (
      .core_clk(core_clk),
      .rstn(rstn),
      .run(timerOn),
      .restart(txStart),
      .inTick(inTick),
      .highCount(txActive && !txStart ? latchedPeriod_reg[15:8] : carrierPeriod_reg[15:8]),
      .lowCount(txActive && !txStart ? latchedPeriod_reg[7:0] : carrierPeriod_reg[7:0]),
      .carrierLevel(carrierLevel),
      .carrierTick(carrierTick)
   );

   // RL8 count clock choice
   assign countTick = ctrl_reg[irt_pkg::CTRL_CLK_SEL_BIT] ? inTick : carrierTick;

   // ****************************************************
   // Transmit sequencing
   // ****************************************************
   // RL9 start on either bit reaching the active pair
   assign txStart = txActive && !txActivePrev_reg;
   assign intervalEnd = txActive && !txStart && countTick && (intervalCounter_reg == '0);
   assign rollOver = rxActive && countTick && (intervalCounter_reg == '1);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         txActivePrev_reg <= 1'b0;
      end else begin
         txActivePrev_reg <= txActive;
      end
   end

   // RL5 RL11 resample at start and each reload
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         latchedPeriod_reg <= irt_pkg::PERIOD_RESET;
         latchedMark_reg <= 1'b0;
         latchedPol_reg <= 1'b0;
      end else if (txStart || intervalEnd) begin
         latchedPeriod_reg <= carrierPeriod_reg;
         latchedMark_reg <= markBit_reg;
         latchedPol_reg <= ctrl_reg[irt_pkg::CTRL_POLARITY_BIT];
      end
   end

   // ****************************************************
   // Interval counter
   // ****************************************************
   // Hardware updates win over a same-cycle software write
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         intervalCounter_reg <= irt_pkg::INTERVAL_RESET;
      end else if (txStart || intervalEnd) begin
         // RL10 RL11 RL12 load gives mark interval plus one ticks
         intervalCounter_reg <= markInterval_reg;
      end else if (txActive && countTick) begin
         intervalCounter_reg <= intervalCounter_reg - 1'b1;
      end else if (captureEvent && ctrl_reg[irt_pkg::CTRL_RELOAD_BIT]) begin
         // RL14 optional clear on capture
         intervalCounter_reg <= '0;
      end else if (rxActive && countTick) begin
         // RL14 RL15 up count wraps to zero
         intervalCounter_reg <= intervalCounter_reg + 1'b1;
      end else if (writeDone && paddr == irt_pkg::INTERVAL_COUNT_OFFSET) begin
         intervalCounter_reg <= pwdata[COUNT_WIDTH-1:0];
      end
   end

   // ****************************************************
   // Mark interval and mark bit
   // ****************************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         markInterval_reg <= irt_pkg::INTERVAL_RESET;
      end else if (captureEvent) begin
         // RL17 capture counter value
         markInterval_reg <= intervalCounter_reg;
      end else if (writeDone && paddr == irt_pkg::MARK_INTERVAL_OFFSET) begin
         markInterval_reg <= pwdata[COUNT_WIDTH-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         markBit_reg <= 1'b0;
      end else if (captureEvent) begin
         // RL17 store sense level
         markBit_reg <= senseSync_reg;
      end else if (writeDone && paddr == irt_pkg::CTRL_OFFSET) begin
         markBit_reg <= pwdata[irt_pkg::CTRL_MARK_BIT];
      end
   end

   // ****************************************************
   // Status flags and interrupt
   // ****************************************************
   assign statusSet[irt_pkg::STATUS_INTERVAL_BIT] = intervalEnd;
   assign statusSet[irt_pkg::STATUS_OVERFLOW_BIT] = rollOver;
   assign statusClr = (writeDone && paddr == irt_pkg::STATUS_OFFSET)
                      ? pwdata[irt_pkg::STATUS_WIDTH-1:0] : '0;

   // RL18 sticky flags, set beats clear
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         status_reg <= irt_pkg::STATUS_RESET;
      end else begin
         status_reg <= (status_reg & ~statusClr) | statusSet;
      end
   end

   // RL11 RL15 interrupt while enabled flag stands
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= ctrl_reg[irt_pkg::CTRL_IRQ_EN_BIT] && |(status_reg & irqMask_reg);
      end
   end

   // ****************************************************
   // Emit pin
   // ****************************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         emitOut_reg <= 1'b0;
         emitOeN_reg <= 1'b1;
      end else if (!timerOn) begin
         // RL1 manual control while off
         emitOut_reg <= powerControl_reg[irt_pkg::PWR_LEVEL_BIT];
         emitOeN_reg <= !powerControl_reg[irt_pkg::PWR_DRIVE_BIT];
      end else if (txActive && !txStart && latchedMark_reg) begin
         // RL7 carrier, inverted by polarity
         emitOut_reg <= carrierLevel ^ latchedPol_reg;
         emitOeN_reg <= 1'b0;
      end else begin
         // RL6 idle level from polarity
         emitOut_reg <= txActive && !txStart ? latchedPol_reg
                        : ctrl_reg[irt_pkg::CTRL_POLARITY_BIT];
         emitOeN_reg <= 1'b0;
      end
   end

   // RL13 stopping is software's act; off or receive ends transmit here
   assign emitPinOut = emitOut_reg;
   assign emitPinOeN = emitOeN_reg;
   assign irq = irq_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

endmodule // irt_carrier_timer

`default_nettype wire

/* File: sim/irt_carrier_timer_checker.sv */
// Purpose: Port assertions for the IR carrier timer.
// Assumes: Shadows follow APB writes that land.
// Notes:   Hardware-only register updates are not shadowed.
`timescale 1ns/1ps
`default_nettype none
module irt_carrier_timer_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sensePin,
   input wire logic emitPinOut,
   input wire logic emitPinOeN,
   input wire logic irq
);
   logic wrLand;
   logic offDrv;
   logic txOn;
   logic [31:0] ctrlReg;
   logic [31:0] pwrReg;
   logic [31:0] maskReg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   assign wrLand = psel && penable && pready && pwrite;
   assign offDrv = !ctrlReg[0] && pwrReg[1];
   assign txOn = ctrlReg[0] && ctrlReg[1];
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ctrlReg <= '0;
         pwrReg <= '0;
         maskReg <= '0;
      end else if (wrLand) begin
         if (paddr == 8'h00) ctrlReg <= pwdata;
         if (paddr == 8'h14) maskReg <= pwdata;
         if (paddr == 8'h18) pwrReg <= pwdata;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   property p_ready_wait;
      psel && $rose(penable) |-> !pready ##1 pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready wait wrong");
   property p_err_map;
      pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18);
   endproperty
   a_err_map: assert property (p_err_map) else $error("pslverr decode wrong");
   property p_rdata_idle;
      prdata != 32'h0000_0000 |-> pready && !pwrite;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata outside read");
   property p_reset_out;
      $rose(rstn) |-> emitPinOeN && !irq && !pready;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not reset");
   property p_manual_pin;
      (offDrv && $stable(pwrReg[0])) [*3] |=> !emitPinOeN && emitPinOut == $past(pwrReg[0]);
   endproperty
   a_manual_pin: assert property (p_manual_pin) else $error("manual pin wrong");
   property p_on_drive;
      txOn [*4] |=> !emitPinOeN;
   endproperty
   a_on_drive: assert property (p_on_drive) else $error("pin not driven");
   property p_irq_off;
      !ctrlReg[10] || maskReg[1:0] == 2'h0 |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   property p_irq_hold;
      !wrLand ##1 irq |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
endmodule // irt_carrier_timer_checker
bind irt_carrier_timer irt_carrier_timer_checker u_chk (.core_clk(core_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sensePin(sensePin),
   .emitPinOut(emitPinOut), .emitPinOeN(emitPinOeN), .irq(irq));
`default_nettype wire

/* File: sim/irt_ir_partner.sv */
// Purpose: Emitter and receiver circuitry beside the timer.
// Assumes: No pull on the emit line.
// Notes:   A released line shows the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none
module irt_ir_partner (
   input wire logic core_clk,
   input wire logic emitPinOut,
   input wire logic emitPinOeN,
   input wire logic senseLevel,
   output logic sensePin,
   output logic emitLine
);
   logic lastLine = 1'b0;
   // Receiver changes just after the edge
   always @(posedge core_clk) begin
      sensePin <= senseLevel;
      if (!emitPinOeN) lastLine <= emitPinOut;
   end
   assign emitLine = emitPinOeN ? !lastLine : emitPinOut;
endmodule // irt_ir_partner
`default_nettype wire

/* File: sim/irt_carrier_timer_tb.sv */
// Purpose: Self-checking bench for the IR carrier timer.
// Assumes: APB slave answers after one wait state.
// Notes:   Emit level is judged on the partner's line.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin totalChecks++; if ((gt) !== (ex)) begin failures++; \
   $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module irt_carrier_timer_tb;
   logic core_clk, rstn, psel, penable, pwrite, senseLevel, sensePin;
   logic pready, pslverr, emitPinOut, emitPinOeN, irq, emitLine;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int failures = 0;
   int totalChecks = 0;
   int cyc = 0;
   irt_carrier_timer u_dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sensePin(sensePin), .emitPinOut(emitPinOut),
      .emitPinOeN(emitPinOeN), .irq(irq));
   irt_ir_partner u_ir (.core_clk(core_clk), .emitPinOut(emitPinOut), .emitPinOeN(emitPinOeN),
      .senseLevel(senseLevel), .sensePin(sensePin), .emitLine(emitLine));
   // ****************************************
   // Bus and wait tasks
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for pready
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
   endtask
   task automatic run(input logic v, output int n);
      n = 0;
      while (emitLine === v && n < 400) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task automatic wirq(output int t);
      while (irq !== 1'b1) begin
         @(posedge core_clk);
      end
      t = cyc;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      logic [31:0] q;
      logic e;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0000_0000, q, e);
         `CHK("resetVal", 32'h0000_0000, q)
         `CHK("unmapped", 1'(i == 7), e)
      end
      wr(8'h04, 32'h0000_A55A);
      rd(8'h04, q);
      `CHK("periodRw", 32'h0000_A55A, q)
   endtask
   task automatic t_carrier(input int dv);
      int n, hi, lo, pol;
      pol = dv % 2;
      wr(8'h04, 32'((dv + 1) << 8 | 1));
      wr(8'h08, 32'h0000_00FF);
      wr(8'h00, 32'(1 + pol * 4 + dv * 32));
      wr(8'h00, 32'(3 + pol * 4 + dv * 32));
      repeat (3) @(posedge core_clk);
      n = 0;
      for (int i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (emitLine !== 1'(pol)) n++;
      end
      `CHK("idleLevel", 0, n)
      wr(8'h00, 32'h0000_0000);
      wr(8'h00, 32'(11 + pol * 4 + dv * 32));
      // First phase may be cut short by the divider phase
      for (int i = 0; i < 2; i++) begin
         run(1'(!pol), n);
         run(1'(pol), n);
      end
      run(1'(!pol), hi);
      run(1'(pol), lo);
      `CHK("carrierHigh", (dv + 2) << dv, hi)
      `CHK("carrierLow", 2 << dv, lo)
      wr(8'h00, 32'h0000_0000);
   endtask
   task automatic t_manual;
      for (int v = 0; v < 2; v++) begin
         wr(8'h18, 32'(2 + v));
         repeat (3) @(posedge core_clk);
         `CHK("manualLvl", 1'(v), emitLine)
         `CHK("manualOe", 1'b0, emitPinOeN)
      end
      wr(8'h18, 32'h0000_0000);
      repeat (3) @(posedge core_clk);
      `CHK("releaseOe", 1'b1, emitPinOeN)
   endtask
   task automatic t_interval;
      int t0, t1;
      logic [31:0] q;
      wr(8'h14, 32'h0000_0001);
      wr(8'h08, 32'h0000_0014);
      wr(8'h00, 32'h0000_0412);
      wr(8'h00, 32'h0000_0413);
      wirq(t0);
      wr(8'h10, 32'h0000_0001);
      @(posedge core_clk);
      `CHK("irqClear", 1'b0, irq)
      wirq(t1);
      `CHK("intervalLen", 21, t1 - t0)
      rd(8'h10, q);
      `CHK("intervalFlag", 32'h0000_0001, q)
      wr(8'h14, 32'h0000_0000);
      wr(8'h10, 32'h0000_0001);
      repeat (30) @(posedge core_clk);
      `CHK("irqMasked", 1'b0, irq)
      rd(8'h10, q);
      `CHK("flagMasked", 32'h0000_0001, q)
      wr(8'h00, 32'h0000_0001); // stop via receive mode
      wr(8'h10, 32'h0000_0003);
      repeat (30) @(posedge core_clk);
      rd(8'h10, q);
      `CHK("stopped", 32'h0000_0000, q)
      wr(8'h00, 32'h0000_0000);
   endtask
   task automatic t_overflow;
      logic [31:0] q, r;
      int t;
      wr(8'h0C, 32'h0000_FF00);
      wr(8'h14, 32'h0000_0002);
      wr(8'h00, 32'h0000_0411);
      rd(8'h0C, q);
      rd(8'h0C, r);
      `CHK("countUp", 1'b1, r > q && q >= 32'h0000_FF00)
      wirq(t);
      rd(8'h10, q);
      `CHK("overflow", 32'h0000_0002, q)
      wr(8'h00, 32'h0000_0000);
      wr(8'h10, 32'h0000_0003);
   endtask
   task automatic t_capture;
      logic [31:0] q;
      for (int c = 0; c < 4; c++) begin
         wr(8'h08, 32'h0000_0000);
         wr(8'h00, 32'(32'h0000_0211 | c << 7));
         senseLevel <= 1'b1;
         repeat (10) @(posedge core_clk);
         senseLevel <= 1'b0;
         repeat (10) @(posedge core_clk);
         rd(8'h08, q);
         `CHK("captured", 1'(c != 0), q != 0)
         if (c == 3) `CHK("reloaded", 1'b1, q < 16)
         rd(8'h00, q);
         `CHK("levelBit", 1'(c == 1), q[3])
         wr(8'h00, 32'h0000_0000);
      end
   endtask
   task end_sim;
      if (failures == 0 && totalChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;
   initial begin
      {rstn, psel, penable, pwrite, senseLevel} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_regs;
      for (int d = 0; d < 4; d++) t_carrier(d);
      t_manual;
      t_interval;
      t_overflow;
      t_capture;
      end_sim;
   end
   // Whole run needs well under this
   initial begin
      repeat (60000) @(posedge core_clk);
      failures++;
      end_sim;
   end
endmodule // irt_carrier_timer_tb
`default_nettype wire
